/* File: bench/logic_program_accumulator_unit_tb.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module logic_program_accumulator_unit_tb;
    import lpa_pkg::*;
    logic        ref_clk     = 1'b0;
    logic        rst_n       = 1'b0;
    logic [7:0]  address     = 8'h00;
    logic        read        = 1'b0;
    logic        write       = 1'b0;
    logic [31:0] writedata   = 32'h00000000;
    logic [3:0]  byteenable  = 4'hF;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        flag_accum;
    logic [15:0] word_accum;
    logic [15:0] shadow [MEM_WORDS];
    logic        ef;
    logic        ill;
    logic [15:0] ew;
    logic [15:0] ref_v;
    logic [31:0] rd;
    int          n_fail          = 0;
    int          samples_checked = 0;
    int          cyc             = 0;

    logic_program_accumulator_unit logic_program_accumulator_unit_i (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .address     (address),
        .read        (read),
        .write       (write),
        .writedata   (writedata),
        .byteenable  (byteenable),
        .readdata    (readdata),
        .waitrequest (waitrequest),
        .flag_accum  (flag_accum),
        .word_accum  (word_accum)
    );

    always #12.5 ref_clk = ~ref_clk;

    // hang guard, the full run needs well under a quarter of this
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test

    // request held until waitrequest is sampled low, then released
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge ref_clk);
        address    <= a;
        writedata  <= d;
        byteenable <= be;
        write      <= 1'b1;
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        address <= a;
        read    <= 1'b1;
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        d = readdata;
        read <= 1'b0;
    endtask : bus_rd

    task automatic mem_wr(input int idx, input logic [15:0] v);
        bus_wr(8'h40 + 8'(idx * 4), {16'h0000, v}, 4'hF);
        shadow[idx] = v;
    endtask : mem_wr

    // expected accumulators and memory kept alongside, then one command issued and checked
    task automatic do_cmd(input logic [3:0] op, input logic [1:0] sp, input logic [15:0] a1, input logic [3:0] a2);
        int          idx;
        logic [15:0] opnd;
        logic        b;
        idx  = (sp == SPACE_SCRATCH) ? 16 : (sp == SPACE_PERSIST) ? 32 : 0;
        idx  = idx + a1[3:0];
        opnd = (sp == SPACE_IMM) ? a1 : shadow[idx];
        b    = opnd[a2];
        ill  = (op > 4'hA) || (op <= 4'h5 && sp == SPACE_IMM);
        if (!ill)
            case (op)
                OP_BIT_LOAD:      ef = b;
                OP_BIT_AND_INV:   ef = ef & ~b;
                OP_BIT_OR:        ef = ef | b;
                OP_BIT_OR_INV:    ef = ef | ~b;
                OP_BIT_STORE:     shadow[idx][a2] = ef;
                OP_BIT_STORE_INV: shadow[idx][a2] = ~ef;
                OP_WORD_LOAD:     ew = opnd;
                OP_WORD_CMP:      shadow[16 + a2][CMP_GT_POS:CMP_LT_POS] = {ew > opnd, ew == opnd, ew < opnd};
                OP_WORD_AND:      ew = ew & opnd;
                OP_WORD_OR:       ew = (sp == SPACE_PERSIST) ? ew ^ opnd : ew | opnd;
                default:          ew = ew ^ opnd;
            endcase
        bus_wr(ARG1_OFS, {16'h0000, a1}, 4'hF);
        bus_wr(ARG2_OFS, {28'h0000000, a2}, 4'hF);
        bus_wr(CMD_OFS, {26'h0000000, op, sp}, 4'hF);
        @(posedge ref_clk);
        #1;
        `CHK(flag_accum, ef)
        `CHK(word_accum, ew)
        bus_rd(STAT_OFS, rd);
        `CHK(rd, {ew, 14'h0000, ill, ef})
        if (op == OP_WORD_CMP)
            idx = 16 + a2;
        bus_rd(8'h40 + 8'(idx * 4), rd);
        `CHK(rd, {16'h0000, shadow[idx]})
    endtask : do_cmd

    initial
    begin
        for (int i = 0; i < MEM_WORDS; i++)
            shadow[i] = WORD_RST;
        ef  = BIT_RST;
        ew  = WORD_RST;
        ill = 1'b0;
        repeat (5) @(posedge ref_clk);
        `CHK(flag_accum, BIT_RST)
        `CHK(word_accum, WORD_RST)
        `CHK(waitrequest, 1'b1)
        rst_n <= 1'b1;
        bus_rd(STAT_OFS, rd);
        `CHK(rd, 32'h00000000)
        // unmapped hole swallows writes and reads as zero
        bus_wr(8'h10, 32'hFFFFFFFF, 4'hF);
        bus_rd(8'h10, rd);
        `CHK(rd, 32'h00000000)
        $display("test reset done");
        mem_wr(3, 16'hA5F0);
        mem_wr(19, 16'h0F0F);
        mem_wr(35, 16'h3C3C);
        mem_wr(25, 16'hF0F1);
        // every word op except compare on every space, immediates including the top value
        for (int s = 0; s < 4; s++)
            for (int o = 6; o < 11; o++)
                if (o != 7)
                    do_cmd(4'(o), 2'(s), (s == 3) ? ((o == 6) ? 16'hFFFF : 16'(o * 16'h1357)) : 16'h0003, 4'h0);
        $display("test word ops done");
        // accumulator just below, equal to and just above each operand
        for (int s = 0; s < 4; s++)
            for (int d = 0; d < 3; d++)
            begin
                ref_v = (s == 3) ? 16'h8000 : shadow[s * 16 + 3];
                do_cmd(OP_WORD_LOAD, SPACE_IMM, ref_v + 16'(d) - 16'h0001, 4'h0);
                do_cmd(OP_WORD_CMP, 2'(s), (s == 3) ? 16'h8000 : 16'h0003, 4'h9);
            end
        $display("test compare done");
        // lowest and highest bit of each space; immediate space is refused for bit ops
        for (int s = 0; s < 4; s++)
            for (int o = 0; o < 6; o++)
                for (int b = 0; b < 16; b += 15)
                    do_cmd(4'(o), 2'(s), 16'h0003, 4'(b));
        $display("test bit ops done");
        for (int o = 11; o < 16; o++)
            do_cmd(4'(o), SPACE_MAIN, 16'h0003, 4'h0);
        $display("test illegal done");
        // command write without lane 0 must not execute
        bus_wr(CMD_OFS, {26'h0000000, OP_WORD_XOR, SPACE_IMM}, 4'hE);
        @(posedge ref_clk);
        #1;
        `CHK(word_accum, ew)
        bus_rd(CMD_OFS, rd);
        `CHK(rd, {26'h0000000, 4'hF, SPACE_MAIN})
        // upper and lower lanes merge separately into a 16-bit field
        bus_wr(8'h40 + 8'(5 * 4), 32'h0000ABCD, 4'h2);
        bus_wr(8'h40 + 8'(5 * 4), 32'h00001234, 4'h1);
        bus_rd(8'h40 + 8'(5 * 4), rd);
        `CHK(rd, {16'h0000, 16'hAB34})
        bus_wr(ARG1_OFS, 32'h0000FFFF, 4'h1);
        bus_rd(ARG1_OFS, rd);
        `CHK(rd, {16'h0000, 16'h00FF})
        $display("test lanes done");
        // reset in mid-run clears accumulators and all three spaces
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        `CHK(flag_accum, BIT_RST)
        `CHK(word_accum, WORD_RST)
        `CHK(waitrequest, 1'b1)
        rst_n <= 1'b1;
        for (int i = 0; i < MEM_WORDS; i++)
            shadow[i] = WORD_RST;
        ef = BIT_RST;
        ew = WORD_RST;
        bus_rd(8'h40 + 8'(35 * 4), rd);
        `CHK(rd, {16'h0000, WORD_RST})
        do_cmd(OP_WORD_OR, SPACE_IMM, 16'h5A5A, 4'h0);
        $display("test mid reset done");
        end_of_test();
    end
endmodule : logic_program_accumulator_unit_tb

/* File: pkg/lpa_pkg.sv */
package lpa_pkg;
    // register map, byte addresses on the slave port
    localparam logic [7:0]  CMD_OFS       = 8'h00;
    localparam logic [7:0]  ARG1_OFS      = 8'h04;
    localparam logic [7:0]  ARG2_OFS      = 8'h08;
    localparam logic [7:0]  STAT_OFS      = 8'h0C;
    // address[7:6] selects a 16-word window: 1 main, 2 scratch, 3 persistent
    localparam logic [1:0]  WIN_NONE      = 2'h0;
    // operand spaces carried in command bits [1:0]
    localparam logic [1:0]  SPACE_MAIN    = 2'h0;
    localparam logic [1:0]  SPACE_SCRATCH = 2'h1;
    localparam logic [1:0]  SPACE_PERSIST = 2'h2;
    localparam logic [1:0]  SPACE_IMM     = 2'h3;
    localparam int          MEM_WORDS     = 48;
    // reset values
    localparam logic [15:0] WORD_RST      = 16'h0000;
    localparam logic        BIT_RST       = 1'b0;
    localparam logic [5:0]  CMD_RST       = 6'h00;
    // compare result positions in the scratch status word
    localparam int          CMP_LT_POS    = 1;
    localparam int          CMP_EQ_POS    = 2;
    localparam int          CMP_GT_POS    = 3;
    // status word layout
    localparam int          STAT_BIT_POS  = 0;
    localparam int          STAT_ILL_POS  = 1;

    typedef enum logic [3:0] {
        OP_BIT_LOAD      = 4'h0,
        OP_BIT_AND_INV   = 4'h1,
        OP_BIT_OR        = 4'h2,
        OP_BIT_OR_INV    = 4'h3,
        OP_BIT_STORE     = 4'h4,
        OP_BIT_STORE_INV = 4'h5,
        OP_WORD_LOAD     = 4'h6,
        OP_WORD_CMP      = 4'h7,
        OP_WORD_AND      = 4'h8,
        OP_WORD_OR       = 4'h9,
        OP_WORD_XOR      = 4'hA
    } op_e;
endpackage : lpa_pkg

/* File: src/logic_program_accumulator_unit.sv */
`timescale 1ns/100ps
// Function
// - persistent inverted bit ANDed into flag
// - register bit ORed into flag accumulator
// - inverted register bit ORed into flag
// - flag copied into chosen register bit
// - inverted flag copied into register bit
// - word commands use 16-bit operands
// - immediate constant loads word accumulator
// - register word loads word accumulator
// - immediate compare sets less/equal/greater bits
// - register compare sets less/equal/greater bits
// - immediate AND result goes to word accumulator
// - register word AND into word accumulator
// - immediate OR into word accumulator
// - main/scratch word OR into accumulator
// - persistent word OR acts as XOR
// - immediate XOR into word accumulator
// - main/scratch word XOR into accumulator
// - one flag and one word accumulator
// - command plus up to two arguments
// - main register bit loads flag accumulator
module logic_program_accumulator_unit
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic             flag_accum,
    output logic      [15:0] word_accum
);
    import lpa_pkg::*;

    // flat index into the three 16-word spaces
    function automatic logic [5:0] mem_index(input logic [1:0] space, input logic [3:0] idx);
        mem_index = {space, idx};
    endfunction : mem_index

    // byte-lane merge of a 16-bit field
    function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] wd,
                                               input logic [3:0] be);
        lane_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : lane_merge

    logic [15:0] mem_q [0:MEM_WORDS-1];
    logic        wait_q;
    logic [31:0] rdata_q;
    logic        flag_q;
    logic        flag_d;
    logic [15:0] word_q;
    logic [15:0] word_d;
    logic [15:0] arg1_q;
    logic [15:0] arg2_q;
    logic [5:0]  cmd_q;
    logic        ill_q;
    logic        ill_d;
    logic        ex_we;
    logic [5:0]  ex_wi;
    logic [15:0] ex_wd;

    // bus decode; one wait cycle, then the request is taken
    wire         req      = read | write;
    wire         take     = req & ~wait_q;
    wire  [1:0]  win      = address[7:6];
    wire  [1:0]  wspace   = win - 2'h1;
    wire  [5:0]  widx     = mem_index(wspace, address[5:2]);
    wire         win_hit  = win != WIN_NONE;
    wire         exec     = take & write & (address == CMD_OFS) & byteenable[0];
    wire  [5:0]  cmd_new  = writedata[5:0];
    wire  [1:0]  space    = cmd_new[1:0];
    wire         imm      = space == SPACE_IMM;
    wire  [3:0]  op_raw   = cmd_new[5:2];
    wire  [5:0]  src_idx  = mem_index(space, arg1_q[3:0]);
    wire  [5:0]  sts_idx  = mem_index(SPACE_SCRATCH, arg2_q[3:0]);
    wire  [3:0]  bit_pos  = arg2_q[3:0];
    // 16-bit operand: constant or addressed register
    wire  [15:0] operand  = imm ? arg1_q : mem_q[src_idx];
    wire         sel_bit  = operand[bit_pos];
    wire  [15:0] bit_mask = 16'h0001 << bit_pos;

    // single-cycle execute; sees the accumulators left by the previous command
    always_comb
    begin
        flag_d = flag_q;
        word_d = word_q;
        ill_d  = 1'b0;
        ex_we  = 1'b0;
        ex_wi  = src_idx;
        ex_wd  = operand;
        case (op_raw)
            // a constant has no bits to test, so bit commands refuse it
            OP_BIT_LOAD:
            begin
                ill_d  = imm;
                flag_d = imm ? flag_q : sel_bit;
            end
            OP_BIT_AND_INV:
            begin
                ill_d  = imm;
                flag_d = imm ? flag_q : flag_q & ~sel_bit;
            end
            OP_BIT_OR:
            begin
                ill_d  = imm;
                flag_d = imm ? flag_q : flag_q | sel_bit;
            end
            OP_BIT_OR_INV:
            begin
                ill_d  = imm;
                flag_d = imm ? flag_q : flag_q | ~sel_bit;
            end
            OP_BIT_STORE, OP_BIT_STORE_INV:
            begin
                // read-modify-write keeps the other fifteen bits
                ill_d = imm;
                ex_we = ~imm;
                ex_wd = (operand & ~bit_mask) |
                        (((op_raw == OP_BIT_STORE) ? {16{flag_q}} : {16{~flag_q}}) & bit_mask);
            end
            OP_WORD_LOAD:     word_d = operand;
            OP_WORD_CMP:
            begin
                // status word in scratch space, only the three result bits change
                ex_we = 1'b1;
                ex_wi = sts_idx;
                ex_wd = mem_q[sts_idx];
                ex_wd[CMP_LT_POS] = word_q < operand;
                ex_wd[CMP_EQ_POS] = word_q == operand;
                ex_wd[CMP_GT_POS] = word_q > operand;
            end
            OP_WORD_AND:      word_d = word_q & operand;
            OP_WORD_OR:
                // persistent space behaves as exclusive OR here
                word_d = (space == SPACE_PERSIST) ? word_q ^ operand : word_q | operand;
            OP_WORD_XOR:      word_d = word_q ^ operand;
            default:          ill_d = 1'b1;
        endcase
    end

    // read mux, loaded during the wait cycle
    wire  [31:0] stat_word = {word_q, 14'h0000, ill_q, flag_q};
    wire  [31:0] rd_mux    = win_hit                 ? {16'h0000, mem_q[widx]} :
                             (address == CMD_OFS)    ? {26'h0000000, cmd_q} :
                             (address == ARG1_OFS)   ? {16'h0000, arg1_q} :
                             (address == ARG2_OFS)   ? {16'h0000, arg2_q} :
                             (address == STAT_OFS)   ? stat_word : 32'h00000000;

    // slave handshake
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            wait_q  <= ~(req & wait_q);
            rdata_q <= (read & wait_q) ? rd_mux : rdata_q;
        end
    end

    // accumulators and argument registers
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flag_q <= BIT_RST;
            word_q <= WORD_RST;
            arg1_q <= WORD_RST;
            arg2_q <= WORD_RST;
            cmd_q  <= CMD_RST;
            ill_q  <= 1'b0;
        end
        else
        begin
            if (exec)
            begin
                flag_q <= flag_d;
                word_q <= word_d;
                cmd_q  <= cmd_new;
                ill_q  <= ill_d;
            end
            if (take & write & (address == ARG1_OFS))
                arg1_q <= lane_merge(arg1_q, writedata, byteenable);
            if (take & write & (address == ARG2_OFS))
                arg2_q <= lane_merge(arg2_q, writedata, byteenable);
        end
    end

    // register spaces; execute and bus never hit the same edge
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < MEM_WORDS; i++)
                mem_q[i] <= WORD_RST;
        end
        else if (exec & ex_we)
            mem_q[ex_wi] <= ex_wd;
        else if (take & write & win_hit)
            mem_q[widx] <= lane_merge(mem_q[widx], writedata, byteenable);
    end

    assign readdata    = rdata_q;
    assign waitrequest = wait_q;
    assign flag_accum  = flag_q;
    assign word_accum  = word_q;

    wire [3:0] op_past = op_raw;

    a_wait_one: assert property (@(posedge ref_clk) disable iff (!rst_n)
        req && wait_q |=> !wait_q ##1 wait_q) else $error("wait cycle count wrong");
    a_flag_or: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && op_past == OP_BIT_OR && !imm |=> flag_q == ($past(flag_q) | $past(sel_bit)))
        else $error("flag OR wrong");
    a_flag_and_inv: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && op_past == OP_BIT_AND_INV && !imm |=> flag_q == ($past(flag_q) & !$past(sel_bit)))
        else $error("flag inverted AND wrong");
    a_store_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && op_past == OP_BIT_STORE && !imm |=> mem_q[$past(src_idx)][$past(bit_pos)] == $past(flag_q))
        else $error("bit store wrong");
    a_store_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && op_past == OP_BIT_STORE_INV && !imm
        |=> (mem_q[$past(src_idx)] & ~$past(bit_mask)) == ($past(operand) & ~$past(bit_mask)))
        else $error("bit store touched other bits");
    a_word_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && op_past == OP_WORD_LOAD |=> word_q == $past(operand)) else $error("word load wrong");
    a_cmp_eq: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && op_past == OP_WORD_CMP
        |=> mem_q[$past(sts_idx)][CMP_EQ_POS] == ($past(word_q) == $past(operand))
            && mem_q[$past(sts_idx)][CMP_LT_POS] == ($past(word_q) < $past(operand)))
        else $error("compare bits wrong");
    a_or_persist: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && op_past == OP_WORD_OR && space == SPACE_PERSIST |=> word_q == ($past(word_q) ^ $past(operand)))
        else $error("persistent OR not exclusive");
    a_xor_word: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && op_past == OP_WORD_XOR |=> word_q == ($past(word_q) ^ $past(operand)))
        else $error("word XOR wrong");

    // bit commands against register bits, and refused on constants
    a_flag_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && op_past == OP_BIT_LOAD && !imm |=> flag_q == $past(sel_bit))
        else $error("flag load wrong");
    a_flag_or_inv: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && op_past == OP_BIT_OR_INV && !imm |=> flag_q == ($past(flag_q) | !$past(sel_bit)))
        else $error("flag inverted OR wrong");
    a_store_inv: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && op_past == OP_BIT_STORE_INV && !imm |=> mem_q[$past(src_idx)][$past(bit_pos)] == !$past(flag_q))
        else $error("inverted bit store wrong");
    a_store_other: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && op_past == OP_BIT_STORE && !imm
        |=> (mem_q[$past(src_idx)] & ~$past(bit_mask)) == ($past(operand) & ~$past(bit_mask)))
        else $error("flag store touched other bits");
    a_bit_refuse: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && op_past <= OP_BIT_STORE_INV && imm |=> ill_q && flag_q == $past(flag_q))
        else $error("bit command on constant not refused");
    a_bit_word_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && op_past <= OP_BIT_STORE_INV |=> word_q == $past(word_q))
        else $error("bit command moved word accumulator");
    // word commands
    a_imm_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && op_past == OP_WORD_LOAD && imm |=> word_q == $past(arg1_q))
        else $error("constant load wrong");
    a_word_flag_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && op_past >= OP_WORD_LOAD && op_past <= OP_WORD_XOR |=> flag_q == $past(flag_q))
        else $error("word command moved flag accumulator");
    a_word_and: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && op_past == OP_WORD_AND |=> word_q == ($past(word_q) & $past(operand)))
        else $error("word AND wrong");
    a_imm_and: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && op_past == OP_WORD_AND && imm |=> word_q == ($past(word_q) & $past(arg1_q)))
        else $error("constant AND wrong");
    a_imm_or: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && op_past == OP_WORD_OR && imm |=> word_q == ($past(word_q) | $past(arg1_q)))
        else $error("constant OR wrong");
    a_word_or: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && op_past == OP_WORD_OR && !imm && space != SPACE_PERSIST
        |=> word_q == ($past(word_q) | $past(operand)))
        else $error("word OR wrong");
    a_reg_xor: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && op_past == OP_WORD_XOR && !imm |=> word_q == ($past(word_q) ^ $past(mem_q[src_idx])))
        else $error("register XOR wrong");
    a_cmp_gt: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && op_past == OP_WORD_CMP |=> mem_q[$past(sts_idx)][CMP_GT_POS] == ($past(word_q) > $past(operand)))
        else $error("compare greater bit wrong");
    a_cmp_one: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && op_past == OP_WORD_CMP |=> $onehot(mem_q[$past(sts_idx)][CMP_GT_POS:CMP_LT_POS]))
        else $error("compare bits not exclusive");
    // sequencing and the bus side
    a_ill_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && op_past > OP_WORD_XOR |=> ill_q && word_q == $past(word_q) && flag_q == $past(flag_q))
        else $error("illegal command had an effect");
    a_idle_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !exec |=> flag_q == $past(flag_q) && word_q == $past(word_q) && ill_q == $past(ill_q))
        else $error("accumulators moved without a command");
    a_cmd_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec |=> cmd_q == $past(cmd_new))
        else $error("command register not updated");
    a_read_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
        read && wait_q |=> readdata == $past(rd_mux))
        else $error("read data not loaded");
endmodule : logic_program_accumulator_unit
